// ---- imt_pkg.sv ----
// Purpose: Constants and types of the I2C master path.
// Assumes: 10 MHz clock, Wishbone classic, byte addresses.
// Notes:   Open-drain; enable high pulls a line low.
// Operation
// - Write sends data byte third, after address and index.
// - Data register meaningless for reads before a start.
// - Received byte is in data register at byte interrupt.
// - Data read before stop fetches one more byte.
// - Data read after stop causes no bus activity.
// - Register index byte follows address byte on writes.
// - Command bit 1 written one makes a stop.
// - Command bit 0 written one makes start, address byte.
// - After address, data goes out on write, in on read.
// - Address bit 0: one read, zero write.
// - Clock held low by peripheral suspends the master.
package imt_pkg;

    localparam logic [7:0]  OFS_TIMING   = 8'h14;
    localparam logic [7:0]  OFS_PERIPH   = 8'h18;
    localparam logic [7:0]  OFS_DATA     = 8'h1c;
    localparam logic [7:0]  OFS_REGIDX   = 8'h20;
    localparam logic [7:0]  OFS_CMD      = 8'h24;
    localparam logic [7:0]  OFS_MODE     = 8'h28;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h2c;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h30;

    localparam int          CMD_START_BIT   = 0;
    localparam int          CMD_STOP_BIT    = 1;
    localparam int          MODE_MANUAL_BIT = 0;
    localparam int          PERIPH_RW_BIT   = 0;
    localparam int          STAT_BUSY_BIT   = 8;
    localparam int          IRQ_W           = 3;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    localparam int          CLK_NS      = 100;
    localparam int          SCL_QTR_NS  = 2500;
    localparam int          QTR_CYC_INT = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  QTR_CYC     = 8'(QTR_CYC_INT);

    typedef struct packed {
        logic [15:0] inter_byte_delay_count;
        logic [15:0] bus_free_count;
    } imt_timing_t;

    typedef struct packed {
        logic stop_done;
        logic nack;
        logic byte_done;
    } imt_irq_t;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_START = 8'h02,
        ST_SHIFT = 8'h04,
        ST_ACK   = 8'h08,
        ST_GAP   = 8'h10,
        ST_WAIT  = 8'h20,
        ST_STOP  = 8'h40,
        ST_FREE  = 8'h80
    } imt_state_t;

    typedef enum logic [3:0] {
        BK_ADDR = 4'h1,
        BK_REG  = 4'h2,
        BK_DATA = 4'h4,
        BK_READ = 4'h8
    } imt_kind_t;

endpackage

// ---- imt_master.sv ----
// Purpose: Register-driven I2C master with Wishbone slave.
// Assumes: Asynchronous line inputs; external pull-ups.
// Notes:   Read bytes always acknowledged.
`timescale 1ns/1ps
module imt_master
    import imt_pkg::*;
(
    input  wire logic        clk_i,     // System clock
    input  wire logic        rst_i,     // Synchronous reset
    input  wire logic [7:0]  wb_adr_i,  // Byte address
    input  wire logic [31:0] wb_dat_i,  // Write data
    output logic      [31:0] wb_dat_o,  // Read data
    input  wire logic        wb_we_i,   // Write enable
    input  wire logic [3:0]  wb_sel_i,  // Byte lanes
    input  wire logic        wb_stb_i,  // Strobe
    input  wire logic        wb_cyc_i,  // Cycle
    output logic             wb_ack_o,  // Acknowledge
    input  wire logic        scl_i,     // Clock line
    output logic             scl_o,     // Constant 0
    output logic             scl_oe_o,  // Pull clock low
    input  wire logic        sda_i,     // Data line
    output logic             sda_o,     // Constant 0
    output logic             sda_oe_o,  // Pull data low
    output logic             irq_o      // Level interrupt
);

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic        scl_m_q;
    logic        scl_s_q;
    logic        sda_m_q;
    logic        sda_s_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    imt_timing_t timing_q;
    logic [7:0]  periph_q;
    logic [7:0]  regidx_q;
    logic [7:0]  data_q;
    logic        manual_q;
    imt_irq_t    irq_stat_q;
    imt_irq_t    irq_mask_q;
    logic        irq_q;
    imt_state_t  st_q;
    imt_kind_t   kind_q;
    logic [1:0]  ph_q;
    logic [7:0]  div_q;
    logic [2:0]  bit_q;
    logic [7:0]  shift_q;
    logic [15:0] dly_q;
    logic        nack_q;
    logic        stop_req_q;
    logic        scl_oe_q;
    logic        sda_oe_q;
    logic        ev_byte_q;
    logic        ev_nack_q;
    logic        ev_stop_q;
    logic        rx_load_q;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        cmd_start;
    logic        cmd_stop;
    logic        data_wr;
    logic        data_rd;
    logic        engine;
    logic        hold;
    logic        tick;
    logic        rx;
    logic [31:0] rd_mux;
    logic [31:0] wide;

    // Two-flop synchronisers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Access lands at the ack edge
    assign acc       = wb_cyc_i & wb_stb_i & ack_q;
    assign wr        = acc & wb_we_i;
    assign rd        = acc & ~wb_we_i;
    assign cmd_start = wr && wb_adr_i == OFS_CMD && wb_sel_i[0]
                       && wb_dat_i[CMD_START_BIT];
    assign cmd_stop  = wr && wb_adr_i == OFS_CMD && wb_sel_i[0]
                       && wb_dat_i[CMD_STOP_BIT];
    assign data_wr   = wr && wb_adr_i == OFS_DATA && wb_sel_i[0];
    assign data_rd   = rd && wb_adr_i == OFS_DATA;
    assign wide      = lane_merge(32'h0, wb_dat_i, wb_sel_i);

    always_comb
    begin
        rd_mux = RST_WORD;
        case (wb_adr_i)
            OFS_TIMING:   rd_mux = timing_q;
            OFS_PERIPH:   rd_mux = {24'h0, periph_q};
            OFS_DATA:     rd_mux = {24'h0, data_q};
            OFS_REGIDX:   rd_mux = {24'h0, regidx_q};
            OFS_MODE:     rd_mux = {31'h0, manual_q};
            OFS_IRQ_STAT: rd_mux = {23'h0, ~(st_q == ST_IDLE), 5'h0, irq_stat_q};
            OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
            default:      rd_mux = RST_WORD;
        endcase
    end

    // One wait state; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= RST_WORD;
        end
        else
        begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i & wb_stb_i & ~ack_q)
            begin
                rdat_q <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Configuration registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timing_q   <= RST_WORD;
            periph_q   <= RST_BYTE;
            regidx_q   <= RST_BYTE;
            manual_q   <= 1'b0;
            irq_mask_q <= '0;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                OFS_TIMING:   timing_q   <= lane_merge(timing_q, wb_dat_i, wb_sel_i);
                OFS_PERIPH:   periph_q   <= wb_sel_i[0] ? wide[7:0] : periph_q;
                OFS_REGIDX:   regidx_q   <= wb_sel_i[0] ? wide[7:0] : regidx_q;
                OFS_MODE:     manual_q   <= wb_sel_i[0] ? wide[MODE_MANUAL_BIT] : manual_q;
                OFS_IRQ_MASK: irq_mask_q <= wb_sel_i[0] ? wide[IRQ_W-1:0] : irq_mask_q;
                default:      manual_q   <= manual_q;
            endcase
        end
    end

    // Received byte beats a software write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_q <= RST_BYTE;
        end
        else if (rx_load_q)
        begin
            data_q <= shift_q;
        end
        else if (data_wr)
        begin
            data_q <= wide[7:0];
        end
    end

    // Sticky W1C status; a new event beats the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q
                           & ~((wr && wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0])
                               ? wide[IRQ_W-1:0] : 3'h0))
                          | {ev_stop_q, ev_nack_q, ev_byte_q};
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign irq_o = irq_q;

    // Quarter-bit divider, frozen while clock is held low
    assign engine = st_q == ST_START || st_q == ST_SHIFT || st_q == ST_ACK
                    || st_q == ST_STOP;
    assign hold   = ~scl_oe_q & ~scl_s_q;
    assign tick   = engine && div_q == 8'h00 && ~hold;
    assign rx     = kind_q == BK_READ;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !engine || tick)
        begin
            div_q <= QTR_CYC - 8'h01;
        end
        else if (!hold)
        begin
            div_q <= div_q - 8'h01;
        end
    end

    // Transfer sequencer and line drive
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_q       <= ST_IDLE;
            kind_q     <= BK_ADDR;
            ph_q       <= 2'h0;
            bit_q      <= 3'h7;
            shift_q    <= RST_BYTE;
            dly_q      <= 16'h0;
            nack_q     <= 1'b0;
            stop_req_q <= 1'b0;
            scl_oe_q   <= 1'b0;
            sda_oe_q   <= 1'b0;
            ev_byte_q  <= 1'b0;
            ev_nack_q  <= 1'b0;
            ev_stop_q  <= 1'b0;
            rx_load_q  <= 1'b0;
        end
        else
        begin
            ev_byte_q <= 1'b0;
            ev_nack_q <= 1'b0;
            ev_stop_q <= 1'b0;
            rx_load_q <= 1'b0;
            if (cmd_stop && st_q != ST_IDLE && st_q != ST_FREE)
            begin
                stop_req_q <= 1'b1;
            end
            if (tick)
            begin
                ph_q <= ph_q + 2'h1;
            end
            case (st_q)
                ST_IDLE:
                begin
                    if (cmd_start)
                    begin
                        st_q       <= ST_START;
                        stop_req_q <= 1'b0;
                        nack_q     <= 1'b0;
                    end
                end
                ST_START:
                begin
                    if (tick)
                    begin
                        case (ph_q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: sda_oe_q <= 1'b1;
                            2'h2: scl_oe_q <= 1'b1;
                            default:
                            begin
                                shift_q <= periph_q;
                                kind_q  <= BK_ADDR;
                                bit_q   <= 3'h7;
                                st_q    <= ST_SHIFT;
                            end
                        endcase
                    end
                end
                ST_SHIFT:
                begin
                    if (tick)
                    begin
                        case (ph_q)
                            2'h0: sda_oe_q <= rx ? 1'b0 : ~shift_q[7];
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2:
                            begin
                                if (rx)
                                begin
                                    shift_q <= {shift_q[6:0], sda_s_q};
                                end
                            end
                            default:
                            begin
                                scl_oe_q <= 1'b1;
                                if (!rx)
                                begin
                                    shift_q <= {shift_q[6:0], 1'b0};
                                end
                                if (bit_q == 3'h0)
                                begin
                                    st_q <= ST_ACK;
                                end
                                bit_q <= bit_q - 3'h1;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (tick)
                    begin
                        case (ph_q)
                            2'h0: sda_oe_q <= rx;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: nack_q   <= ~rx & sda_s_q;
                            default:
                            begin
                                scl_oe_q <= 1'b1;
                                sda_oe_q <= 1'b0;
                                dly_q    <= timing_q.inter_byte_delay_count;
                                st_q     <= ST_GAP;
                            end
                        endcase
                    end
                end
                ST_GAP:
                begin
                    bit_q <= 3'h7;
                    if (dly_q != 16'h0)
                    begin
                        dly_q <= dly_q - 16'h1;
                    end
                    else if (nack_q)
                    begin
                        ev_nack_q <= 1'b1;
                        st_q      <= ST_STOP;
                    end
                    else
                    begin
                        case (kind_q)
                            BK_ADDR:
                            begin
                                st_q <= ST_SHIFT;
                                if (periph_q[PERIPH_RW_BIT])
                                begin
                                    kind_q <= BK_READ;
                                end
                                else
                                begin
                                    kind_q  <= BK_REG;
                                    shift_q <= regidx_q;
                                end
                            end
                            BK_REG:
                            begin
                                kind_q  <= BK_DATA;
                                shift_q <= data_q;
                                st_q    <= ST_SHIFT;
                            end
                            BK_DATA:
                            begin
                                ev_byte_q <= 1'b1;
                                st_q      <= (manual_q && !stop_req_q) ? ST_WAIT : ST_STOP;
                            end
                            default:
                            begin
                                rx_load_q <= 1'b1;
                                ev_byte_q <= 1'b1;
                                st_q      <= stop_req_q ? ST_STOP : ST_WAIT;
                            end
                        endcase
                    end
                end
                ST_WAIT:
                begin
                    // Manual writes resend via index path
                    if (stop_req_q || cmd_stop)
                    begin
                        st_q <= ST_STOP;
                    end
                    else if (kind_q == BK_DATA && data_wr)
                    begin
                        kind_q <= BK_REG;
                        dly_q  <= 16'h0;
                        st_q   <= ST_GAP;
                    end
                    else if (rx && data_rd)
                    begin
                        bit_q <= 3'h7;
                        st_q  <= ST_SHIFT;
                    end
                end
                ST_STOP:
                begin
                    if (tick)
                    begin
                        case (ph_q)
                            2'h0:
                            begin
                                scl_oe_q <= 1'b1;
                                sda_oe_q <= 1'b1;
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0;
                            default:
                            begin
                                ev_stop_q  <= 1'b1;
                                stop_req_q <= 1'b0;
                                dly_q      <= timing_q.bus_free_count;
                                st_q       <= ST_FREE;
                            end
                        endcase
                    end
                end
                ST_FREE:
                begin
                    if (dly_q != 16'h0)
                    begin
                        dly_q <= dly_q - 16'h1;
                    end
                    else
                    begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Open-drain: only ever pull low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;

endmodule

// ---- imt_master_asserts.sv ----
// Purpose: Port assertions for the I2C master transfer path.
// Assumes: Bound to imt_master; start and stop only written when legal.
// Notes:   Idle means both lines quiet for over 100 cycles.
`timescale 1ns/1ps
module imt_master_asserts
    import imt_pkg::*;
(
    input wire logic        clk_i,    // Clock
    input wire logic        rst_i,    // Reset
    input wire logic [7:0]  wb_adr_i, // Address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic        wb_we_i,  // Write
    input wire logic [3:0]  wb_sel_i, // Lanes
    input wire logic        wb_stb_i, // Strobe
    input wire logic        wb_cyc_i, // Cycle
    input wire logic        wb_ack_o, // Ack
    input wire logic        scl_i,    // Clock line
    input wire logic        scl_o,    // Clock drive
    input wire logic        scl_oe_o, // Clock pull
    input wire logic        sda_i,    // Data line
    input wire logic        sda_o,    // Data drive
    input wire logic        sda_oe_o, // Data pull
    input wire logic        irq_o     // Interrupt
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       cmd_wr;
    logic [7:0] quiet_q;
    assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                    && wb_adr_i == OFS_CMD;
    // A long quiet spell means idle
    always_ff @(posedge clk_i)
        if (rst_i || scl_oe_o || sda_oe_o || !scl_i || !sda_i)
            quiet_q <= 8'h00;
        else if (quiet_q != 8'hff)
            quiet_q <= quiet_q + 8'h01;
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_wait; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o; endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("ack not one cycle late");
    property p_rst_quiet; @(posedge clk_i) disable iff (1'b0)
        rst_i |=> !wb_ack_o && !scl_oe_o && !sda_oe_o && !irq_o; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
    property p_wo_zero; wb_ack_o && !wb_we_i && (wb_adr_i == OFS_CMD
        || wb_adr_i > OFS_IRQ_MASK) |-> wb_dat_o == 32'h0; endproperty
    a_wo_zero: assert property (p_wo_zero) else $error("command or hole read nonzero");
    property p_start; cmd_wr && wb_dat_i[0] && quiet_q > 8'd100
        |-> ##[1:80] (sda_oe_o && !scl_oe_o); endproperty
    a_start: assert property (p_start) else $error("no start condition");
    property p_zero; cmd_wr && wb_dat_i[1:0] == 2'b00 && quiet_q > 8'd100
        |=> (!scl_oe_o && !sda_oe_o)[*8]; endproperty
    a_zero: assert property (p_zero) else $error("zero command moved the bus");
    property p_stop; cmd_wr && wb_dat_i[1]
        |-> ##[1:400] (!scl_oe_o && $fell(sda_oe_o)); endproperty
    a_stop: assert property (p_stop) else $error("no stop condition");
    property p_stretch; (!scl_oe_o && !scl_i)[*4]
        |-> $stable(sda_oe_o) && $stable(scl_oe_o); endproperty
    a_stretch: assert property (p_stretch) else $error("moved while held");
    property p_quarter; $changed(scl_oe_o) |=> $stable(scl_oe_o)[*8]; endproperty
    a_quarter: assert property (p_quarter) else $error("clock pull changed too soon");
    c_start: cover property (cmd_wr && wb_dat_i[0]);
    c_stretch: cover property ((!scl_oe_o && !scl_i)[*4]);
    c_irq: cover property ($rose(irq_o));
endmodule

// ---- imt_periph_model.sv ----
// Purpose: Behavioural peripheral on the serial bus.
// Assumes: Wired-and lines with pull-ups in the bench.
// Notes:   Read bytes are tx_byte_i plus byte count, MSB forced high.
`timescale 1ns/1ps
module imt_periph_model
(
    input  wire logic       scl_i,     // Clock line
    input  wire logic       sda_i,     // Data line
    input  wire logic [7:0] tx_byte_i, // Read data base
    output logic            scl_oe_o,  // Pull clock low
    output logic            sda_oe_o,  // Pull data low
    output logic      [7:0] rx_byte_o, // Last byte taken
    output logic            rx_tgl_o,  // Toggles per byte taken
    output int              cnt_o      // Bytes completed
);
    logic [7:0] sh, txs;
    logic       act = 1'b0, first = 1'b0, rd = 1'b0;
    int         bitn = 0;
    initial
    begin
        {scl_oe_o, sda_oe_o, rx_tgl_o, rx_byte_o} = 11'h0;
        cnt_o = 0;
    end
    always @(negedge sda_i)
        if (scl_i === 1'b1)
        begin
            {act, first, rd} = 3'b110;
            bitn = 0;
        end
    always @(posedge sda_i)
        if (scl_i === 1'b1)
            act = 1'b0;
    always @(posedge scl_i)
        if (act)
        begin
            sh = {sh[6:0], sda_i};
            bitn++;
        end
    always @(negedge scl_i)
        if (act)
        begin
            if (bitn == 8)
            begin
                sda_oe_o = first || !rd;
                if (sda_oe_o)
                    {rx_tgl_o, rx_byte_o} = {!rx_tgl_o, sh};
                if (first)
                    rd = sh[0];
            end
            else if (bitn == 9)
            begin
                bitn = 0;
                cnt_o++;
                first = 1'b0;
                // MSB high keeps data free while master waits
                txs = (tx_byte_i + 8'(cnt_o)) | 8'h80;
                sda_oe_o = 1'b0;
                scl_oe_o = 1'b1;
                // Long enough to outlast the master's own low phase
                #8000 scl_oe_o = 1'b0;
            end
            else if (rd && !first)
                sda_oe_o = !txs[7 - bitn];
        end
endmodule

// ---- imt_master_tb.sv ----
// Purpose: Self-checking bench for imt_master.
// Assumes: Pull-ups on both lines; 10 MHz clock.
// Notes:   Reads and bytes are checked against queued notes.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module imt_master_tb;
    import imt_pkg::*;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} imt_note_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, tx_byte = 8'h00, rx_byte, pid, idx, dat, bexp;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_ack_o, scl_oe_o, sda_oe_o, irq_o, m_scl_oe, m_sda_oe, rx_tgl;
    wire         scl = ~(scl_oe_o | m_scl_oe);
    wire         sda = ~(sda_oe_o | m_sda_oe);
    int          mismatches = 0, cmp_count = 0, nbytes;
    imt_note_t   rd_q[$];
    logic [7:0]  by_q[$];
    imt_master dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
        .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o),
        .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
    imt_periph_model peer (.scl_i(scl), .sda_i(sda), .tx_byte_i(tx_byte), .scl_oe_o(m_scl_oe),
        .sda_oe_o(m_sda_oe), .rx_byte_o(rx_byte), .rx_tgl_o(rx_tgl), .cnt_o(nbytes));
    initial
        forever #50 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
        begin
            imt_note_t t;
            t = rd_q.pop_front();
            `CHK("read data", t.e & t.m, wb_dat_o & t.m)
        end
    always @(rx_tgl)
        if ($time > 0)
        begin
            bexp = (by_q.size() > 0) ? by_q.pop_front() : ~rx_byte;
            `CHK("bus byte", bexp, rx_byte)
        end
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i} <= {a, w, d, 4'hf};
        {wb_cyc_i, wb_stb_i} <= 2'b11;
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
            @(posedge clk_i);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n == 20)
        begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rd_q.push_back('{e, m});
        wb(a, 1'b0, 32'h0);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 5000 && irq_o !== 1'b1; n++)
            @(posedge clk_i);
        if (n == 5000)
        begin
            mismatches++;
            close_out();
        end
    endtask
    initial
    begin
        int i;
        void'($urandom(32'hebc8));
        pid = 8'($urandom) & 8'hfe;
        idx = 8'($urandom);
        dat = 8'($urandom);
        tx_byte <= 8'($urandom);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (120) @(posedge clk_i);
        rd(OFS_DATA, 32'h0, 32'hffff_ffff);
        rd(OFS_REGIDX, 32'h0, 32'hffff_ffff);
        wb(OFS_CMD, 1'b1, 32'h0);
        rd(OFS_CMD, 32'h0, 32'hffff_ffff);
        rd(8'h3c, 32'h0, 32'hffff_ffff);
        // Manual write: second byte loaded after interrupt
        wb(OFS_TIMING, 1'b1, {16'd10, 16'd15});
        wb(OFS_MODE, 1'b1, 32'h1);
        wb(OFS_PERIPH, 1'b1, {24'h0, pid});
        wb(OFS_REGIDX, 1'b1, {24'h0, idx});
        wb(OFS_DATA, 1'b1, {24'h0, dat});
        rd(OFS_REGIDX, {24'h0, idx}, 32'hffff_ffff);
        by_q = '{pid, idx, dat, ~dat};
        wb(OFS_IRQ_MASK, 1'b1, 32'h1);
        wb(OFS_CMD, 1'b1, 32'h1);
        wait_irq();
        wb(OFS_IRQ_STAT, 1'b1, 32'h1);
        wb(OFS_DATA, 1'b1, {24'h0, ~dat});
        `CHK("irq cleared", 1'b0, irq_o)
        wait_irq();
        wb(OFS_IRQ_STAT, 1'b1, 32'h1);
        wb(OFS_IRQ_MASK, 1'b1, 32'h4);
        wb(OFS_CMD, 1'b1, 32'h2);
        wait_irq();
        rd(OFS_IRQ_STAT, 32'h4, 32'h7);
        wb(OFS_IRQ_MASK, 1'b1, 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK("irq masked", 1'b0, irq_o)
        wb(OFS_IRQ_STAT, 1'b1, 32'h4);
        wb(OFS_IRQ_MASK, 1'b1, 32'h1);
        // Read: each data read before stop fetches a byte
        wb(OFS_MODE, 1'b1, 32'h0);
        wb(OFS_PERIPH, 1'b1, {24'h0, pid | 8'h01});
        by_q.push_back(pid | 8'h01);
        wb(OFS_CMD, 1'b1, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            wait_irq();
            wb(OFS_IRQ_STAT, 1'b1, 32'h1);
            if (i < 2)
                rd(OFS_DATA, {24'h0, (tx_byte + 8'(5 + i)) | 8'h80}, 32'hff);
        end
        wb(OFS_IRQ_MASK, 1'b1, 32'h4);
        wb(OFS_CMD, 1'b1, 32'h2);
        wait_irq();
        rd(OFS_DATA, {24'h0, (tx_byte + 8'd7) | 8'h80}, 32'hff);
        repeat (300) @(posedge clk_i);
        `CHK("byte count", 8, nbytes)
        `CHK("bytes missing", 0, by_q.size())
        close_out();
    end
endmodule
bind imt_master imt_master_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .irq_o(irq_o));
